// file: hw/lhcu_ctrl.sv
// link host control register pair with its event bits and request gating
// assumes an apb master on pclk and link request strobes on the same clock
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "lhcu_consts.svh"

module lhcu_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic global_reset_pin_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic eeprom_load_valid,
    input wire logic eeprom_phy_config_bit,
    input wire logic req_valid,
    input wire logic req_to_node,
    input wire logic req_rom_block_read,
    input wire logic bus_reset,
    input wire logic rom_fetch_error,
    output logic ack_valid,
    output logic [3:0] ack_code,
    output logic rom_read_accept,
    output logic rom_atomic_update_en,
    output logic rom_regs_update,
    output logic byte_swap_disable,
    output logic late_ack_enable,
    output logic phy_config_delegated,
    output logic phy_enhancement_enable,
    output logic link_power_on,
    output logic posted_write_enable,
    output logic link_active_enable,
    output logic soft_reset_pulse,
    output logic irq
);

    // apb decode; read data and error taken in the setup phase, writes in the access phase
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire hit_set = paddr == `LHCU_ADDR_CTRL_SET;
    wire hit_clr = paddr == `LHCU_ADDR_CTRL_CLR;
    wire hit_stat = paddr == `LHCU_ADDR_EVT_STAT;
    wire hit_eclr = paddr == `LHCU_ADDR_EVT_CLR;
    wire hit_en = paddr == `LHCU_ADDR_EVT_EN;
    wire mapped = hit_set | hit_clr | hit_stat | hit_eclr | hit_en;
    wire wr = access & pwrite & mapped;

    // byte lanes widen to a bit mask for set and clear writes
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    wire [31:0] wbits = pwdata & lane_mask(pstrb);
    wire ctrl_set_wr = wr & hit_set;
    wire ctrl_clr_wr = wr & hit_clr;
    wire evt_clr_wr = wr & hit_eclr;
    wire evt_en_wr = wr & hit_en;

    // control state
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic deleg_q;
    logic [31:0] evt_q;
    logic [31:0] evt_d;
    logic [31:0] en_q;
    logic [31:0] en_d;
    lhcu_pkg::lhcu_state_t st_q;
    lhcu_pkg::lhcu_state_t st_d;
    logic [31:0] rdata_q;
    logic err_q;
    logic ack_valid_q;
    logic [3:0] ack_code_q;
    logic accept_q;
    logic rom_upd_q;

    wire soft_rst = st_q == lhcu_pkg::LHCU_SRST;
    wire link_en = ctrl_q[`LHCU_BIT_LINK_EN];
    wire rom_valid = ctrl_q[`LHCU_BIT_ROM_VALID];
    wire late_ack = ctrl_q[`LHCU_BIT_LATE_ACK];

    // soft reset: bit 16 stays high for the reset cycle and the cycle after it, then drops
    always_comb begin
        st_d = st_q;
        case (st_q)
            lhcu_pkg::LHCU_RUN: begin
                if (ctrl_set_wr && wbits[`LHCU_BIT_SOFT_RST]) begin
                    st_d = lhcu_pkg::LHCU_SRST;
                end
            end
            lhcu_pkg::LHCU_SRST: begin
                st_d = lhcu_pkg::LHCU_SDONE;
            end
            lhcu_pkg::LHCU_SDONE: begin
                st_d = lhcu_pkg::LHCU_RUN;
            end
            default: begin
                st_d = lhcu_pkg::LHCU_RUN;
            end
        endcase
    end

    // writable set/clear bits; image valid may be set but never cleared by software
    wire [31:0] sw_set = wbits & `LHCU_CTRL_SW_MASK & {32{ctrl_set_wr}}; // RULE14 RULE16
    wire [31:0] sw_clr = wbits & `LHCU_CTRL_SW_MASK & {32{ctrl_clr_wr}}; // RULE14 RULE16
    // image valid set only while the link is off, so a live link never sees it appear
    wire rom_set = ctrl_set_wr & wbits[`LHCU_BIT_ROM_VALID] & ~link_en; // RULE4

    always_comb begin
        ctrl_d = (ctrl_q | sw_set) & ~sw_clr;
        ctrl_d[`LHCU_BIT_ROM_VALID] = rom_valid | rom_set;
        // a fetch error wins over a same-cycle software set
        if (rom_fetch_error) begin
            ctrl_d[`LHCU_BIT_ROM_VALID] = 1'b0; // RULE5
        end
        ctrl_d[`LHCU_BIT_SOFT_RST] = 1'b0;
        if (st_d == lhcu_pkg::LHCU_SRST) begin
            ctrl_d[`LHCU_BIT_SOFT_RST] = 1'b1;
        end
        if (soft_rst) begin
            ctrl_d = 32'h00000000; // RULE5 RULE15
            ctrl_d[`LHCU_BIT_SOFT_RST] = 1'b1;
        end
        ctrl_d[28:24] = 5'h00; // RULE11
        ctrl_d[23] = 1'b0;
        ctrl_d[21:20] = 2'h0;
        ctrl_d[15:0] = 16'h0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h00000000; // RULE15
            st_q <= lhcu_pkg::LHCU_RUN;
        end else begin
            ctrl_q <= ctrl_d;
            st_q <= st_d;
        end
    end

    // bit 23 answers only to the global reset pin and the eeprom loader
    always_ff @(posedge pclk or negedge global_reset_pin_n) begin
        if (!global_reset_pin_n) begin
            deleg_q <= `LHCU_PHY_DELEG_RESET; // RULE12
        end else if (eeprom_load_valid) begin
            deleg_q <= eeprom_phy_config_bit; // RULE12
        end
    end

    // requests are seen only while the link is enabled and not in soft reset
    wire live = link_en & ~soft_rst; // RULE15
    wire req = req_valid & req_to_node & live;
    wire send_tardy = req & late_ack; // RULE7
    wire rom_rd = req & ~late_ack & req_rom_block_read;
    wire rom_ok = rom_rd & rom_valid; // RULE1
    wire rom_bad = rom_rd & ~rom_valid; // RULE2

    logic [3:0] code_d;
    always_comb begin
        code_d = `LHCU_ACK_COMPLETE;
        if (send_tardy) begin
            code_d = `LHCU_ACK_TARDY; // RULE7
        end else if (rom_bad) begin
            code_d = `LHCU_ACK_TYPE_ERR; // RULE2
        end else if (rom_ok) begin
            code_d = `LHCU_ACK_PENDING; // RULE1
        end
    end

    // shadow rom registers reload on bus reset only with a valid image
    wire rom_upd_d = bus_reset & rom_valid & link_en; // RULE3

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_valid_q <= 1'b0;
            ack_code_q <= 4'h0;
            accept_q <= 1'b0;
            rom_upd_q <= 1'b0;
        end else begin
            ack_valid_q <= req;
            ack_code_q <= req ? code_d : 4'h0;
            accept_q <= rom_ok;
            rom_upd_q <= rom_upd_d;
        end
    end

    // sticky events; a set in the clear cycle survives
    wire [31:0] evt_hit = {4'h0, send_tardy, 25'h0000000, rom_fetch_error, bus_reset & live};
    wire [31:0] evt_wclr = wbits & {32{evt_clr_wr}};

    always_comb begin
        evt_d = ((evt_q & ~evt_wclr) | evt_hit) & `LHCU_EVT_MASK; // RULE8
        en_d = evt_en_wr ? (wbits & `LHCU_EVT_MASK) : en_q;
        if (soft_rst) begin
            evt_d = 32'h00000000;
            en_d = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_q <= 32'h00000000;
            en_q <= 32'h00000000;
        end else begin
            evt_q <= evt_d;
            en_q <= en_d;
        end
    end

    // read mux; the clear registers of the event pair read as zero
    wire [31:0] ctrl_rd = {ctrl_q[31:24], deleg_q, ctrl_q[22:0]}; // RULE11 RULE12 RULE16
    wire [31:0] rd_mux = (hit_set | hit_clr) ? ctrl_rd :
                         hit_stat ? evt_q :
                         hit_en ? en_q : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else if (setup) begin
            rdata_q <= pwrite ? 32'h00000000 : rd_mux;
            err_q <= ~mapped;
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = access & err_q;

    assign ack_valid = ack_valid_q;
    assign ack_code = ack_code_q;
    assign rom_read_accept = accept_q;
    assign rom_atomic_update_en = rom_valid; // RULE1
    assign rom_regs_update = rom_upd_q;
    assign byte_swap_disable = ctrl_q[`LHCU_BIT_NO_SWAP]; // RULE6
    assign late_ack_enable = late_ack;
    assign phy_config_delegated = deleg_q;
    assign phy_enhancement_enable = ctrl_q[`LHCU_BIT_PHY_ENH];
    assign link_power_on = ctrl_q[`LHCU_BIT_LPS];
    assign posted_write_enable = ctrl_q[`LHCU_BIT_POSTED];
    assign link_active_enable = link_en; // RULE15
    assign soft_reset_pulse = soft_rst;
    assign irq = |(evt_q & en_q);

endmodule
`default_nettype wire

// file: shared/lhcu_consts.svh
// constants of the link host control block: offsets, bit positions, reset values
// assumes the includer maps the registers on a 32-bit apb word bus
// What the document requires of this block and its software
// RULE1: while the image-valid bit is 1, config-rom block reads are answered and atomic rom update is allowed.
// RULE2: while the image-valid bit is 0, config-rom block reads get ack_type_error.
// RULE3: a bus reset while the image-valid bit is 0 leaves rom mapping, rom header and bus options untouched.
// RULE4: software builds the bus info image first and sets the image-valid bit only while link enable is 0.
// RULE5: once set, the image-valid bit clears only by hardware reset, soft reset or a bus info fetch error.
// RULE6: bit 30 selects whether off-chip physical accesses and other dma data are byte swapped.
// RULE7: with late-ack enable set, accesses to this node are acknowledged with ack_tardy.
// RULE8: each ack_tardy sent sets the ack_tardy event bit 27.
// RULE9: before the d1 power state software clears the ack_tardy event and unmasks phy and ack_tardy wake events.
// RULE10: software never sets late-ack enable while this node is bus manager.
// RULE11: bits 28 to 24 always read as zero.
// RULE12: bit 23 is read-only, defaults to 1, loads from eeprom and resets only by the global reset pin.
// RULE13: the driver owns phy enhancements and bit 22 only while bit 23 is 1.
// RULE14: the control register has a set address and a clear address.
// RULE15: link enable clears on hardware or soft reset, and while 0 the link neither receives nor sends.
// RULE16: reads at either address return the register, and a written 0 leaves its bit unchanged.
`ifndef LHCU_CONSTS_SVH
`define LHCU_CONSTS_SVH
`define LHCU_ADDR_CTRL_SET 12'h050
`define LHCU_ADDR_CTRL_CLR 12'h054
`define LHCU_ADDR_EVT_STAT 12'h080
`define LHCU_ADDR_EVT_CLR 12'h084
`define LHCU_ADDR_EVT_EN 12'h088
`define LHCU_BIT_ROM_VALID 31
`define LHCU_BIT_NO_SWAP 30
`define LHCU_BIT_LATE_ACK 29
`define LHCU_BIT_PHY_DELEG 23
`define LHCU_BIT_PHY_ENH 22
`define LHCU_BIT_LPS 19
`define LHCU_BIT_POSTED 18
`define LHCU_BIT_LINK_EN 17
`define LHCU_BIT_SOFT_RST 16
`define LHCU_CTRL_SW_MASK 32'h604f0000
`define LHCU_EVT_BIT_TARDY 27
`define LHCU_EVT_BIT_FETCH 1
`define LHCU_EVT_BIT_BUSRST 0
`define LHCU_EVT_MASK 32'h08000003
`define LHCU_PHY_DELEG_RESET 1'b1
`define LHCU_ACK_PENDING 4'h2
`define LHCU_ACK_TARDY 4'hb
`define LHCU_ACK_TYPE_ERR 4'he
`define LHCU_ACK_COMPLETE 4'h1
`endif

// file: shared/lhcu_pkg.sv
// types of the link host control block
// assumes nothing beyond a systemverilog compiler
package lhcu_pkg;
    typedef enum logic [2:0] {
        LHCU_RUN = 3'b001,
        LHCU_SRST = 3'b010,
        LHCU_SDONE = 3'b100
    } lhcu_state_t;
endpackage

// file: verif/lhcu_ctrl_asserts.sv
// port checker of the link host control block
// assumes one pclk domain and is bound onto lhcu_ctrl
`timescale 1ns/10ps
`default_nettype none
`include "lhcu_consts.svh"
module lhcu_ctrl_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic req_valid,
    input wire logic req_to_node,
    input wire logic req_rom_block_read,
    input wire logic bus_reset,
    input wire logic rom_fetch_error,
    input wire logic ack_valid,
    input wire logic [3:0] ack_code,
    input wire logic rom_read_accept,
    input wire logic rom_atomic_update_en,
    input wire logic rom_regs_update,
    input wire logic late_ack_enable,
    input wire logic link_active_enable,
    input wire logic soft_reset_pulse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire tk = req_valid && req_to_node && link_active_enable && !soft_reset_pulse;
    wire rom = tk && !late_ack_enable && req_rom_block_read;
    wire rdc = psel && penable && !pwrite && (paddr == `LHCU_ADDR_CTRL_SET || paddr == `LHCU_ADDR_CTRL_CLR);
    a_tardy_answer: assert property (tk && late_ack_enable |=> ack_valid && ack_code == `LHCU_ACK_TARDY)
        else $error("late ack not answered tardy");
    a_rom_accepted: assert property (rom && rom_atomic_update_en |=> rom_read_accept && ack_code == `LHCU_ACK_PENDING)
        else $error("rom read not accepted");
    a_rom_refused: assert property (rom && !rom_atomic_update_en |=> ack_code == `LHCU_ACK_TYPE_ERR && !rom_read_accept)
        else $error("rom read not refused");
    a_accept_code: assert property (rom_read_accept |-> ack_valid && ack_code == `LHCU_ACK_PENDING)
        else $error("accept without pending ack");
    a_link_silent: assert property (!link_active_enable |=> !ack_valid)
        else $error("ack while link off");
    a_no_reload: assert property (bus_reset && !rom_atomic_update_en |=> !rom_regs_update)
        else $error("rom regs reloaded while image invalid");
    a_image_sticky: assert property (rom_atomic_update_en && !rom_fetch_error && !soft_reset_pulse |=> rom_atomic_update_en)
        else $error("image valid dropped");
    a_reserved_zero: assert property (rdc |-> prdata[28:24] == 5'h00)
        else $error("reserved bits nonzero");
endmodule
bind lhcu_ctrl lhcu_ctrl_asserts u_chk (.*);
`default_nettype wire

// file: verif/lhcu_node_model.sv
// remote bus node: sends async packets, bus resets and rom fetch errors
// assumes each taken packet is answered one cycle later
`timescale 1ns/10ps
`default_nettype none
module lhcu_node_model (
    input wire logic pclk,
    input wire logic ack_valid,
    input wire logic [3:0] ack_code,
    output logic req_valid,
    output logic req_to_node,
    output logic req_rom_block_read,
    output logic bus_reset,
    output logic rom_fetch_error
);
    initial {req_valid, req_to_node, req_rom_block_read, bus_reset, rom_fetch_error} = 5'h00;
    task automatic send(input logic rd, output logic [3:0] code);
        code = 4'h0;
        req_valid <= 1'b1;
        req_to_node <= 1'b1;
        req_rom_block_read <= rd;
        @(posedge pclk);
        req_valid <= 1'b0;
        // qualifiers flip once released so a stale value is never trusted
        req_to_node <= 1'b0;
        req_rom_block_read <= ~rd;
        repeat (2) begin
            @(posedge pclk);
            if (ack_valid === 1'b1) code = ack_code;
        end
    endtask
    task automatic event_pulse(input logic fetch);
        bus_reset <= ~fetch;
        rom_fetch_error <= fetch;
        @(posedge pclk);
        {bus_reset, rom_fetch_error} <= 2'b00;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// file: verif/link_host_control_upper_bits_tb.sv
// testbench of the link host control block: apb master and remote node model
// assumes lhcu_ctrl, lhcu_node_model and the bound checker; pclk 200 MHz
`timescale 1ns/10ps
`default_nettype none
`include "lhcu_consts.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module link_host_control_upper_bits_tb;
    logic pclk, presetn, global_reset_pin_n, psel, penable, pwrite, eeprom_load_valid, eeprom_phy_config_bit;
    logic [11:0] paddr;
    logic [3:0] pstrb, ack_code, c;
    logic [31:0] pwdata, prdata, d;
    logic pready, pslverr, err, ack_valid, req_valid, req_to_node, req_rom_block_read, bus_reset, rom_fetch_error;
    logic rom_read_accept, rom_atomic_update_en, rom_regs_update, byte_swap_disable, late_ack_enable, irq;
    logic phy_config_delegated, phy_enhancement_enable, link_power_on, posted_write_enable, link_active_enable;
    logic soft_reset_pulse;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int reloads = 0;
    lhcu_ctrl DUT (.*);
    lhcu_node_model node (.*);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic complete_run();
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // reload pulses are counted at the edge so checks never race the pulse itself
    always @(posedge pclk) begin
        if (rom_regs_update === 1'b1) begin
            reloads <= reloads + 1;
        end
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    initial begin
        {psel, penable, pwrite, eeprom_load_valid, eeprom_phy_config_bit, presetn, global_reset_pin_n} = 7'h00;
        {paddr, pwdata} = 44'h0;
        pstrb = 4'hf;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        global_reset_pin_n <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `LHCU_ADDR_CTRL_SET, 32'h0);
        `CHK("ctrl reset", 32'h00800000, d)
        node.send(1'b0, c);
        `CHK("ack link off", 4'h0, c)
        apb(1'b1, `LHCU_ADDR_CTRL_SET, 32'h80000000);
        apb(1'b1, `LHCU_ADDR_CTRL_SET, 32'h000a0000);
        node.event_pulse(1'b0);
        apb(1'b0, `LHCU_ADDR_CTRL_CLR, 32'h0);
        `CHK("ctrl at clear addr", 32'h808a0000, d)
        `CHK("rom reload", 1, reloads)
        apb(1'b1, `LHCU_ADDR_CTRL_SET, 32'h5f000000);
        apb(1'b1, `LHCU_ADDR_CTRL_CLR, 32'h80000000);
        apb(1'b0, `LHCU_ADDR_CTRL_SET, 32'h0);
        `CHK("reserved and sticky", 32'hc08a0000, d)
        `CHK("swap pin", 1'b1, byte_swap_disable)
        apb(1'b1, `LHCU_ADDR_CTRL_CLR, 32'h40000000);
        node.send(1'b1, c);
        `CHK("rom read", `LHCU_ACK_PENDING, c)
        apb(1'b1, `LHCU_ADDR_EVT_EN, 32'h08000000);
        apb(1'b1, `LHCU_ADDR_CTRL_SET, 32'h20000000);
        node.send(1'b1, c);
        `CHK("tardy", `LHCU_ACK_TARDY, c)
        apb(1'b0, `LHCU_ADDR_EVT_STAT, 32'h0);
        `CHK("tardy event", 32'h08000000, d & 32'h08000000)
        `CHK("irq on", 1'b1, irq)
        apb(1'b1, `LHCU_ADDR_EVT_CLR, 32'h08000000);
        `CHK("irq cleared", 1'b0, irq)
        apb(1'b1, `LHCU_ADDR_EVT_EN, 32'h0);
        node.send(1'b0, c);
        apb(1'b0, `LHCU_ADDR_EVT_STAT, 32'h0);
        `CHK("masked event", 32'h08000000, d & 32'h08000000)
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, `LHCU_ADDR_CTRL_CLR, 32'h20000000);
        node.event_pulse(1'b1);
        apb(1'b0, `LHCU_ADDR_CTRL_SET, 32'h0);
        `CHK("fetch error", 32'h008a0000, d)
        node.send(1'b1, c);
        `CHK("rom refused", `LHCU_ACK_TYPE_ERR, c)
        node.event_pulse(1'b0);
        apb(1'b0, 12'hffc, 32'h0);
        `CHK("unmapped", 1'b1, err)
        `CHK("no reload invalid", 1, reloads)
        apb(1'b1, `LHCU_ADDR_CTRL_SET, 32'h00010000);
        repeat (4) @(posedge pclk);
        apb(1'b0, `LHCU_ADDR_CTRL_SET, 32'h0);
        `CHK("soft reset", 32'h00800000, d)
        eeprom_load_valid <= 1'b1;
        @(posedge pclk);
        eeprom_load_valid <= 1'b0;
        @(posedge pclk);
        `CHK("eeprom load", 1'b0, phy_config_delegated)
        global_reset_pin_n <= 1'b0;
        @(posedge pclk);
        global_reset_pin_n <= 1'b1;
        @(posedge pclk);
        `CHK("pin reset", 1'b1, phy_config_delegated)
        complete_run();
    end
endmodule
`default_nettype wire
